// *** logic/rxh_top.sv ***
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "rxh_defines.svh"
module rxh_top #(
	parameter bit          HAS_FPU = 1'b1,          // Float unit present
	parameter logic [31:0] VERSION = 32'h0000_1234, // Arbitrary identity value
	parameter int          ZERO_N  = 7              // Zero-reset registers
) (
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire logic           hard_reset_pin,
	input  wire logic           soft_reset_pin,
	input  wire logic           por_busy,
	input  wire logic [31:0]    next_pc,
	input  wire logic           next_done,
	input  wire logic           store_queue_empty,
	input  wire logic           machine_check_take,
	input  wire logic           mispredict_next,
	input  wire logic           state_corrupt,
	input  wire logic           float_instr_exec,
	input  wire rxh_pkg::rxh_axi_req_t s_axi_req,
	output rxh_pkg::rxh_axi_rsp_t      s_axi_rsp,
	output logic                fetch_valid,
	output logic [31:0]         fetch_addr,
	output logic                block_completion,
	output logic                icache_disable,
	output logic                cache_invalidate,
	output logic [1:0]          lru_init_side0,
	output logic [1:0]          lru_init_side1,
	output logic                checkstop_enable,
	output logic                test_io_release,
	output logic                float_unavail_exc,
	output logic                real_addressing,
	output logic                core_hold
);
	import rxh_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic        hard_s1_q, hard_s2_q;  // Hard reset pin stages
	logic        soft_s1_q, soft_s2_q;  // Soft reset pin stages

	// Two flops per pin; only the second stage is used
	always_ff @(posedge clk) begin
		hard_s1_q <= hard_reset_pin;
		hard_s2_q <= hard_s1_q;
		soft_s1_q <= soft_reset_pin;
		soft_s2_q <= soft_s1_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Reset sources
	wire hard_any = rst | hard_s2_q | por_busy;
	logic [1:0]  soft_cnt_q;   // Cycles soft pin seen high
	logic        soft_seen_q;  // Soft reset recognised

	// Count soft pin high time; recognise after the minimum
	always_ff @(posedge clk) begin
		if (hard_any || !soft_s2_q) begin
			soft_cnt_q <= 2'h0;
		end else if (soft_cnt_q != 2'(`RXH_SOFT_MIN_CYC)) begin
			soft_cnt_q <= soft_cnt_q + 2'h1;
		end
	end
	wire soft_ok = soft_s2_q && (soft_cnt_q == 2'(`RXH_SOFT_MIN_CYC - 1));

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	rxh_state_t  state_q, state_d;   // Current and next state
	logic [1:0]  dly_q;              // Hard vector delay
	logic        mc_seen_q;          // Machine check during drain
	logic [31:0] msr_q, saved_pc_q, saved_state_q, timer_q;
	logic [31:0] zero_q [ZERO_N];    // Zeroed-at-reset registers

	// Writable and implemented state bits
	wire [31:0] msr_mask = HAS_FPU ? `RXH_MSR_MASK_FPU : `RXH_MSR_MASK_NOFPU;
	wire drained = next_done && store_queue_empty;
	wire soft_go = drained && !machine_check_take;
	wire take_soft = (state_q == RXH_SOFT_DRAIN) && soft_go;
	wire lost_rec = mc_seen_q || machine_check_take || state_corrupt;

	// State after a reset exception: keep EXCEPTION_ENDIAN_SELECT, ME, IP; LE from EXCEPTION_ENDIAN_SELECT
	wire [31:0] msr_exc = (msr_q & `RXH_MSR_KEEP)
		| {31'h0, msr_q[`RXH_ILE]};
	// Saved state: upper half clear, lower half copied except RI, which is cleared when recovery is lost
	wire [31:0] ss_new = {16'h0, msr_q[15:2], ~lost_rec & msr_q[`RXH_RI],
		msr_q[0]};

	// Next-state logic; hard reset overrides all else
	always_comb begin
		state_d = state_q;
		case (state_q)
			RXH_RUN: begin
				if (soft_ok) begin
					state_d = RXH_SOFT_DRAIN;
				end
			end
			RXH_HARD_HOLD: begin
				state_d = RXH_HARD_VEC;
			end
			RXH_HARD_VEC: begin
				if (dly_q == 2'h0) begin
					state_d = RXH_RUN;
				end
			end
			RXH_SOFT_DRAIN: begin
				if (soft_go) begin
					state_d = RXH_SOFT_WAIT;
				end
			end
			RXH_SOFT_WAIT: begin
				if (!soft_s2_q) begin
					state_d = RXH_RUN;
				end
			end
			default: begin
				state_d = RXH_RUN;
			end
		endcase
		if (hard_any) begin
			state_d = RXH_HARD_HOLD;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		state_q <= state_d;
	end

	// Hard vector delay: one cycle, longer after a mispredict
	always_ff @(posedge clk) begin
		if (state_q == RXH_HARD_HOLD) begin
			dly_q <= mispredict_next ? 2'(`RXH_MISPRED_DLY) : 2'h0;
		end else if (dly_q != 2'h0) begin
			dly_q <= dly_q - 2'h1;
		end
	end

	// Remember a machine check seen while draining
	always_ff @(posedge clk) begin
		if (state_q != RXH_SOFT_DRAIN) begin
			mc_seen_q <= 1'b0;
		end else if (machine_check_take) begin
			mc_seen_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic        aw_have_q, w_have_q;  // Address and data held
	logic [7:0]  aw_addr_q;            // Held write address
	logic [31:0] w_data_q;             // Held write data
	logic [3:0]  w_strb_q;             // Held strobes
	logic        bvalid_q, rvalid_q;   // Response pending
	logic [1:0]  bresp_q, rresp_q;     // Response codes
	logic [31:0] rdata_q;              // Read data

	wire awready = !aw_have_q && !bvalid_q;
	wire wready  = !w_have_q && !bvalid_q;
	wire arready = !rvalid_q;
	wire wr_fire = aw_have_q && w_have_q;
	wire rd_fire = s_axi_req.arvalid && arready;

	// Byte-lane merge of held data
	wire [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [31:0] m);
		merge = (old_v & ~m) | (new_v & m);
	endfunction

	// Write address decode
	wire [5:0] wr_idx = aw_addr_q[7:2];
	wire wr_msr = wr_fire && (aw_addr_q == `RXH_OFF_MSR);
	wire wr_pc  = wr_fire && (aw_addr_q == `RXH_OFF_SAVED_PC);
	wire wr_ss  = wr_fire && (aw_addr_q == `RXH_OFF_SAVED_STATE);
	wire wr_tmr = wr_fire && (aw_addr_q == `RXH_OFF_TIMER);
	wire wr_zero_rng = (aw_addr_q >= `RXH_OFF_ZERO_BASE)
		&& (aw_addr_q < `RXH_OFF_ZERO_BASE + 8'(4 * ZERO_N));
	wire wr_ok = (aw_addr_q[1:0] == 2'h0)
		&& (wr_msr || wr_pc || wr_ss || wr_tmr || wr_zero_rng);

	// Channel capture and write response
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `RXH_RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (s_axi_req.awvalid && awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_req.awaddr;
			end
			if (s_axi_req.wvalid && wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_req.wdata;
				w_strb_q <= s_axi_req.wstrb;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_ok ? `RXH_RESP_OKAY : `RXH_RESP_DECERR;
			end else if (bvalid_q && s_axi_req.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read decode
	wire [7:0] ra = s_axi_req.araddr;
	wire [5:0] ra_zi = 6'(ra[7:2] - `RXH_OFF_ZERO_BASE / 4);
	wire ra_zero = (ra >= `RXH_OFF_ZERO_BASE)
		&& (ra < `RXH_OFF_ZERO_BASE + 8'(4 * ZERO_N));
	wire [31:0] status_w = {24'h0, cache_invalidate, icache_disable,
		block_completion, mc_seen_q, 1'b0, state_q};
	wire rd_hit = (ra[1:0] == 2'h0) && (ra_zero || ra == `RXH_OFF_MSR
		|| ra == `RXH_OFF_SAVED_PC || ra == `RXH_OFF_SAVED_STATE
		|| ra == `RXH_OFF_TIMER || ra == `RXH_OFF_VERSION
		|| ra == `RXH_OFF_STATUS);
	wire [31:0] rd_val =
		!rd_hit                       ? 32'h0000_0000 :
		ra_zero                       ? zero_q[ra_zi[2:0]] :
		(ra == `RXH_OFF_MSR)          ? (msr_q & msr_mask) :
		(ra == `RXH_OFF_SAVED_PC)     ? saved_pc_q :
		(ra == `RXH_OFF_SAVED_STATE)  ? saved_state_q :
		(ra == `RXH_OFF_TIMER)        ? timer_q :
		(ra == `RXH_OFF_VERSION)      ? VERSION : status_w;

	// Read channel
	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `RXH_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_val;
			rresp_q  <= rd_hit ? `RXH_RESP_OKAY : `RXH_RESP_DECERR;
		end else if (rvalid_q && s_axi_req.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Slave outputs
	assign s_axi_rsp.awready = awready;
	assign s_axi_rsp.wready  = wready;
	assign s_axi_rsp.bvalid  = bvalid_q;
	assign s_axi_rsp.bresp   = bresp_q;
	assign s_axi_rsp.arready = arready;
	assign s_axi_rsp.rvalid  = rvalid_q;
	assign s_axi_rsp.rdata   = rdata_q;
	assign s_axi_rsp.rresp   = rresp_q;

	////////////////////////////////////////////////////////////////////////
	// Architected registers; hardware events win over bus writes
	always_ff @(posedge clk) begin
		if (hard_any) begin
			msr_q         <= `RXH_MSR_RESET;
			saved_pc_q    <= `RXH_ZERO_RESET;
			saved_state_q <= `RXH_ZERO_RESET;
			timer_q       <= `RXH_DEC_RESET;
		end else if (take_soft) begin
			msr_q         <= msr_exc & msr_mask;
			saved_pc_q    <= next_pc;
			saved_state_q <= ss_new & msr_mask;
		end else begin
			if (wr_msr) begin
				msr_q <= merge(msr_q, w_data_q, strb_mask) & msr_mask;
			end
			if (wr_pc) begin
				saved_pc_q <= merge(saved_pc_q, w_data_q, strb_mask);
			end
			if (wr_ss) begin
				saved_state_q <= merge(saved_state_q, w_data_q, strb_mask);
			end
			if (wr_tmr) begin
				timer_q <= merge(timer_q, w_data_q, strb_mask);
			end else begin
				timer_q <= timer_q - 32'h0000_0001;
			end
		end
	end

	// Zero-reset registers: condition, link, count, time base, scratch, config
	genvar gi;
	generate
		for (gi = 0; gi < ZERO_N; gi++) begin : g_zero
			wire hit = wr_fire && (wr_idx == 6'(`RXH_OFF_ZERO_BASE / 4 + gi));
			always_ff @(posedge clk) begin
				if (hard_any) begin
					zero_q[gi] <= `RXH_ZERO_RESET;
				end else if (hit) begin
					zero_q[gi] <= merge(zero_q[gi], w_data_q, strb_mask);
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Core-facing outputs
	logic        fetch_valid_q;   // Handler fetch pulse
	logic [31:0] fetch_addr_q;    // Handler address
	logic        icache_dis_q;    // Instruction cache off
	logic        inval_q;         // Cache invalidate level
	logic        ckstp_en_q;      // Checkstop detection on
	logic        test_rel_q;      // Pins with functional logic
	logic        fpu_exc_q;       // Float unavailable pulse

	// Vector selection and cache control
	always_ff @(posedge clk) begin
		if (hard_any) begin
			fetch_valid_q <= 1'b0;
			fetch_addr_q  <= `RXH_VEC_HIGH;
			icache_dis_q  <= 1'b0;
			inval_q       <= 1'b1;
			ckstp_en_q    <= 1'b1;
			test_rel_q    <= 1'b1;
			fpu_exc_q     <= 1'b0;
		end else begin
			inval_q       <= 1'b0;
			fpu_exc_q     <= !HAS_FPU && float_instr_exec;
			fetch_valid_q <= 1'b0;
			if (state_q == RXH_HARD_VEC && dly_q == 2'h0) begin
				fetch_valid_q <= 1'b1;
				fetch_addr_q  <= `RXH_VEC_HIGH;
			end else if (state_q == RXH_SOFT_WAIT && !soft_s2_q) begin
				fetch_valid_q <= 1'b1;
				fetch_addr_q  <= msr_q[`RXH_IP] ? `RXH_VEC_HIGH : `RXH_VEC_LOW;
			end
			if (take_soft) begin
				icache_dis_q <= 1'b1;
			end
		end
	end

	assign fetch_valid       = fetch_valid_q;
	assign fetch_addr        = fetch_addr_q;
	assign block_completion  = (state_q == RXH_SOFT_DRAIN);
	assign icache_disable    = icache_dis_q;
	assign cache_invalidate  = inval_q;
	assign lru_init_side0    = 2'h0;
	assign lru_init_side1    = 2'h1;
	assign checkstop_enable  = ckstp_en_q;
	assign test_io_release   = test_rel_q;
	assign float_unavail_exc = fpu_exc_q;
	assign real_addressing   = !msr_q[`RXH_IR] && !msr_q[`RXH_DR];
	assign core_hold         = (state_q != RXH_RUN);
endmodule : rxh_top

// *** logic/rxh_defines.svh ***
`ifndef RXH_DEFINES_SVH
`define RXH_DEFINES_SVH
// How it works
// - Reset exception nonmaskable, vector offset 0x00100
// - Soft reset vector chosen by prefix bit
// - Hard reset branches at once to 0xFFF00100
// - Hard reset highest priority, never recoverable
// - Soft reset drains to recoverable state first
// - Soft reset keeps latches, disables instruction cache
// - Soft reset ranks below hard and machine check
// - Machine check during drain makes soft unrecoverable
// - Saved PC gets next completing instruction address
// - Saved state: upper half cleared, low half copied
// - Corrupt state clears recoverable bit in saved state
// - Endian copies exception endian; listed bits cleared
// - Hard reset: state 0x40, timer FFFFFFF, others zero
// - Hard reset invalidates cache, distinct replacement bits
// - External checkstop detection enabled after hard reset
// - Test interface returns I/O pins after hard reset
// - Translation off after reset: real addressing
// - Reserved state bits read as zero
// - No-float variant: float bits held at zero
// - No-float variant: float instruction raises unavailable
// - Hard reset latency one cycle, three on mispredict

// Vector offset and handler bases
`define RXH_VEC_OFFSET      32'h0000_0100
`define RXH_VEC_LOW         32'h0000_0100
`define RXH_VEC_HIGH        32'hFFF0_0100
// Reset values
`define RXH_MSR_RESET       32'h0000_0040
`define RXH_DEC_RESET       32'h0FFF_FFFF
`define RXH_ZERO_RESET      32'h0000_0000
// Machine state bit positions (bit 0 is the least significant)
`define RXH_POW             18
`define RXH_TLB_SHADOW_REGS            17
`define RXH_ILE             16
`define RXH_EE              15
`define RXH_PR              14
`define RXH_FP              13
`define RXH_ME              12
`define RXH_FE0             11
`define RXH_SE              10
`define RXH_BE              9
`define RXH_FE1             8
`define RXH_IP              6
`define RXH_IR              5
`define RXH_DR              4
`define RXH_RI              1
`define RXH_LE              0
// Implemented state bits, with and without a float unit
`define RXH_MSR_MASK_FPU    32'h0007_FF73
`define RXH_MSR_MASK_NOFPU  32'h0007_D673
// Bits kept across a reset exception: EXCEPTION_ENDIAN_SELECT, ME, IP
`define RXH_MSR_KEEP        32'h0001_1040
// Register byte offsets
`define RXH_OFF_MSR         8'h00
`define RXH_OFF_SAVED_PC    8'h04
`define RXH_OFF_SAVED_STATE 8'h08
`define RXH_OFF_TIMER       8'h0C
`define RXH_OFF_ZERO_BASE   8'h10
`define RXH_OFF_VERSION     8'h2C
`define RXH_OFF_STATUS      8'h30
// Timing
`define RXH_SOFT_MIN_CYC    2
`define RXH_MISPRED_DLY     2
// Bus responses
`define RXH_RESP_OKAY       2'h0
`define RXH_RESP_DECERR     2'h3
`endif

// *** logic/rxh_pkg.sv ***
package rxh_pkg;
	// Sequencer states
	typedef enum logic [2:0] {
		RXH_RUN,
		RXH_HARD_HOLD,
		RXH_HARD_VEC,
		RXH_SOFT_DRAIN,
		RXH_SOFT_WAIT
	} rxh_state_t;

	// Master to slave AXI4-Lite signals
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} rxh_axi_req_t;

	// Slave to master AXI4-Lite signals
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} rxh_axi_rsp_t;
endpackage : rxh_pkg

// *** verif/rxh_checker.sv ***
`timescale 1ns/1ps
`include "rxh_defines.svh"
module rxh_checker #(
	parameter bit HAS_FPU = 1'b1 // Float unit present
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        hard_reset_pin,
	input wire logic        por_busy,
	input wire logic        next_done,
	input wire logic        store_queue_empty,
	input wire logic        machine_check_take,
	input wire logic        float_instr_exec,
	input wire logic        fetch_valid,
	input wire logic [31:0] fetch_addr,
	input wire logic        block_completion,
	input wire logic        icache_disable,
	input wire logic        cache_invalidate,
	input wire logic [1:0]  lru_init_side0,
	input wire logic [1:0]  lru_init_side1,
	input wire logic        checkstop_enable,
	input wire logic        test_io_release,
	input wire logic        float_unavail_exc,
	input wire logic        real_addressing,
	input wire logic        core_hold
);
	logic [3:0] hard_q; // Recent hard pin history, covers the sync lag
	logic       quiet;  // No hard reset source anywhere near
	////////////////////////////////////////////////////////////////
	// History shift; cleared by reset so quiet is known at release
	always_ff @(posedge clk) begin
		hard_q <= rst ? 4'h0 : {hard_q[2:0], hard_reset_pin};
	end
	assign quiet = (hard_q == 4'h0) && !hard_reset_pin && !por_busy;
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Handler fetch at the fixed high base
	sequence s_hard_vec;
		fetch_valid && (fetch_addr == `RXH_VEC_HIGH);
	endsequence
	// Drain not yet finished
	sequence s_drain_open;
		block_completion && !(next_done && store_queue_empty && !machine_check_take);
	endsequence
	// Reset outputs seen at the first edge after release, while still launched by reset
	a_reset_hold: assert property ($fell(rst) |->
		core_hold && cache_invalidate && !fetch_valid)
		else $error("Outputs wrong while hard reset held");
	a_reset_state: assert property ($fell(rst) |->
		checkstop_enable && test_io_release)
		else $error("Checkstop or test I/O state wrong after reset");
	a_reset_real: assert property ($fell(rst) |->
		real_addressing && !icache_disable)
		else $error("Not in real addressing after reset");
	a_hard_fetch: assert property ($fell(rst) && quiet |-> ##[1:4] s_hard_vec)
		else $error("No high base fetch after hard reset");
	a_fetch_pulse: assert property (fetch_valid |=> !fetch_valid)
		else $error("Fetch strobe longer than one cycle");
	a_vector_base: assert property (fetch_valid |-> fetch_addr inside {`RXH_VEC_LOW, `RXH_VEC_HIGH})
		else $error("Fetch address not a reset vector");
	a_drain_hold: assert property (s_drain_open ##0 quiet |=> block_completion)
		else $error("Drain ended early");
	a_icache_soft: assert property ($fell(block_completion) && quiet && !$past(rst) |-> icache_disable)
		else $error("Instruction cache not disabled by soft reset");
	a_float_exc: assert property (float_instr_exec |=> float_unavail_exc == !HAS_FPU)
		else $error("Float unavailable flag wrong");
	a_lru_distinct: assert property (lru_init_side0 != lru_init_side1)
		else $error("Replacement bits not distinct");
endmodule : rxh_checker

bind rxh_top rxh_checker #(.HAS_FPU(HAS_FPU)) i_chk (
	.clk(clk), .rst(rst), .hard_reset_pin(hard_reset_pin), .por_busy(por_busy),
	.next_done(next_done), .store_queue_empty(store_queue_empty),
	.machine_check_take(machine_check_take), .float_instr_exec(float_instr_exec),
	.fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .block_completion(block_completion),
	.icache_disable(icache_disable), .cache_invalidate(cache_invalidate),
	.lru_init_side0(lru_init_side0), .lru_init_side1(lru_init_side1),
	.checkstop_enable(checkstop_enable), .test_io_release(test_io_release),
	.float_unavail_exc(float_unavail_exc), .real_addressing(real_addressing),
	.core_hold(core_hold)
);

// *** verif/rxh_reset_src.sv ***
`timescale 1ns/1ps
module rxh_reset_src (
	input  wire logic clk,
	output logic      hard_reset_pin,
	output logic      soft_reset_pin
);
	// Both requests idle low
	initial begin
		hard_reset_pin = 1'b0;
		soft_reset_pin = 1'b0;
	end
	// Soft request held n clocks; below two only when a refusal is wanted
	task automatic pulse_soft(input int n);
		soft_reset_pin <= 1'b1;
		repeat (n) @(posedge clk);
		soft_reset_pin <= 1'b0;
	endtask : pulse_soft
	// Hard request held n clocks
	task automatic pulse_hard(input int n);
		hard_reset_pin <= 1'b1;
		repeat (n) @(posedge clk);
		hard_reset_pin <= 1'b0;
	endtask : pulse_hard
endmodule : rxh_reset_src

// *** verif/rxh_top_tb.sv ***
`timescale 1ns/1ps
`include "rxh_defines.svh"
module rxh_top_tb;
	import rxh_pkg::*;
`define RXH_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); end end
	localparam logic [31:0] VER = 32'h0000_00A5; // Arbitrary identity value
	logic         clk, rst, por_busy, next_done, store_queue_empty, machine_check_take;
	logic         mispredict_next, state_corrupt, float_instr_exec, fetch_valid;
	logic         block_completion, icache_disable, cache_invalidate, checkstop_enable;
	logic         test_io_release, float_unavail_exc, real_addressing, core_hold, inv_seen;
	logic [31:0]  next_pc, fetch_addr, last_fa, d;
	logic [1:0]   lru_init_side0, lru_init_side1;
	wire          hard_reset_pin, soft_reset_pin;
	rxh_axi_req_t req;
	rxh_axi_rsp_t rsp;
	int           mismatches, num_checks, cyc, fetch_n;
	////////////////////////////////////////////////////////////////
	rxh_top #(.HAS_FPU(1'b0), .VERSION(VER), .ZERO_N(7)) i_dut (
		.clk(clk), .rst(rst), .hard_reset_pin(hard_reset_pin), .soft_reset_pin(soft_reset_pin),
		.por_busy(por_busy), .next_pc(next_pc), .next_done(next_done),
		.store_queue_empty(store_queue_empty), .machine_check_take(machine_check_take),
		.mispredict_next(mispredict_next), .state_corrupt(state_corrupt),
		.float_instr_exec(float_instr_exec), .s_axi_req(req), .s_axi_rsp(rsp),
		.fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .block_completion(block_completion),
		.icache_disable(icache_disable), .cache_invalidate(cache_invalidate),
		.lru_init_side0(lru_init_side0), .lru_init_side1(lru_init_side1),
		.checkstop_enable(checkstop_enable), .test_io_release(test_io_release),
		.float_unavail_exc(float_unavail_exc), .real_addressing(real_addressing),
		.core_hold(core_hold));
	rxh_reset_src i_src (.clk(clk), .hard_reset_pin(hard_reset_pin), .soft_reset_pin(soft_reset_pin));
	////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Fetch monitor and hang guard
	always @(posedge clk) begin
		cyc++;
		if (fetch_valid === 1'b1) begin
			fetch_n <= fetch_n + 1;
			last_fa <= fetch_addr;
		end
		if (cache_invalidate === 1'b1) inv_seen <= 1'b1;
		if (cyc == 4000) begin
			mismatches++;
			$display("CHECK FAILED t=%0t timeout", $time);
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////
	// Bus write, both channels offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= v;
		req.wstrb   <= 4'hF;
		do begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		`RXH_CHK(rsp.bresp, er)
	endtask : axi_wr
	// Bus read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		do begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		v = rsp.rdata;
		`RXH_CHK(rsp.rresp, er)
	endtask : axi_rd
	// Read and compare
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		axi_rd(a, v, `RXH_RESP_OKAY);
		`RXH_CHK(v, e)
	endtask : rd_chk
	// Wait for a new handler fetch
	task automatic wait_fetch(input int n0);
		do @(posedge clk); while (fetch_n == n0);
	endtask : wait_fetch
	// Soft reset with drain; optional corruption or machine check
	task automatic do_soft(input logic corrupt, input logic mc);
		int n0;
		n0 = fetch_n;
		state_corrupt <= corrupt;
		i_src.pulse_soft(3);
		do @(posedge clk); while (block_completion !== 1'b1);
		repeat (3) @(posedge clk);
		`RXH_CHK(block_completion, 1'b1)
		next_done          <= 1'b1;
		store_queue_empty  <= 1'b1;
		machine_check_take <= mc;
		repeat (3) @(posedge clk);
		`RXH_CHK(block_completion, mc)
		machine_check_take <= 1'b0;
		wait_fetch(n0);
		next_done         <= 1'b0;
		store_queue_empty <= 1'b0;
		state_corrupt     <= 1'b0;
	endtask : do_soft
	////////////////////////////////////////////////////////////////
	task automatic t_hard_init();
		repeat (6) @(posedge clk);
		`RXH_CHK(last_fa, `RXH_VEC_HIGH)
		`RXH_CHK(inv_seen, 1'b1)
		`RXH_CHK(lru_init_side0 != lru_init_side1, 1'b1)
		`RXH_CHK({checkstop_enable, test_io_release}, 2'b11)
		`RXH_CHK({real_addressing, icache_disable}, 2'b10)
		rd_chk(`RXH_OFF_MSR, `RXH_MSR_RESET);
		rd_chk(`RXH_OFF_SAVED_PC, 32'h0000_0000);
		rd_chk(`RXH_OFF_SAVED_STATE, 32'h0000_0000);
		for (int i = 0; i < 7; i++) rd_chk(`RXH_OFF_ZERO_BASE + 8'(4 * i), 32'h0);
		axi_rd(`RXH_OFF_TIMER, d, `RXH_RESP_OKAY);
		`RXH_CHK(d > 32'h0FFF_FF00 && d <= `RXH_DEC_RESET, 1'b1)
		rd_chk(`RXH_OFF_VERSION, VER);
		$display("t_hard_init done");
	endtask : t_hard_init
	task automatic t_bus_map();
		axi_wr(`RXH_OFF_MSR, 32'hFFFF_FFFF, `RXH_RESP_OKAY);
		rd_chk(`RXH_OFF_MSR, `RXH_MSR_MASK_NOFPU);
		`RXH_CHK(real_addressing, 1'b0)
		axi_wr(8'h40, 32'h0000_0001, `RXH_RESP_DECERR);
		axi_rd(8'h40, d, `RXH_RESP_DECERR);
		`RXH_CHK(d, 32'h0000_0000)
		$display("t_bus_map done");
	endtask : t_bus_map
	task automatic t_soft_low();
		axi_wr(`RXH_OFF_MSR, 32'h0001_9032, `RXH_RESP_OKAY);
		do_soft(1'b0, 1'b0);
		`RXH_CHK(last_fa, `RXH_VEC_LOW)
		rd_chk(`RXH_OFF_SAVED_PC, 32'h0000_2468);
		rd_chk(`RXH_OFF_SAVED_STATE, 32'h0000_9032);
		rd_chk(`RXH_OFF_MSR, 32'h0001_1001);
		`RXH_CHK({icache_disable, real_addressing}, 2'b11)
		$display("t_soft_low done");
	endtask : t_soft_low
	task automatic t_soft_mc();
		axi_wr(`RXH_OFF_MSR, 32'h0000_0042, `RXH_RESP_OKAY);
		next_pc <= 32'h0000_1358;
		do_soft(1'b0, 1'b1);
		`RXH_CHK(last_fa, `RXH_VEC_HIGH)
		rd_chk(`RXH_OFF_SAVED_PC, 32'h0000_1358);
		rd_chk(`RXH_OFF_SAVED_STATE, 32'h0000_0040);
		rd_chk(`RXH_OFF_MSR, 32'h0000_0040);
		$display("t_soft_mc done");
	endtask : t_soft_mc
	task automatic t_soft_corrupt();
		axi_wr(`RXH_OFF_MSR, 32'h0000_0042, `RXH_RESP_OKAY);
		do_soft(1'b1, 1'b0);
		rd_chk(`RXH_OFF_SAVED_STATE, 32'h0000_0040);
		$display("t_soft_corrupt done");
	endtask : t_soft_corrupt
	task automatic t_soft_short();
		int n0;
		n0 = fetch_n;
		i_src.pulse_soft(1);
		repeat (10) @(posedge clk);
		`RXH_CHK({core_hold, fetch_n == n0}, 2'b01)
		$display("t_soft_short done");
	endtask : t_soft_short
	task automatic t_hard_abort();
		int n0;
		axi_wr(`RXH_OFF_MSR, 32'h0000_0000, `RXH_RESP_OKAY);
		mispredict_next <= 1'b1;
		i_src.pulse_soft(3);
		do @(posedge clk); while (block_completion !== 1'b1);
		n0 = fetch_n;
		i_src.pulse_hard(3);
		wait_fetch(n0);
		mispredict_next <= 1'b0;
		`RXH_CHK(last_fa, `RXH_VEC_HIGH)
		`RXH_CHK(icache_disable, 1'b0)
		rd_chk(`RXH_OFF_MSR, `RXH_MSR_RESET);
		n0 = fetch_n;
		por_busy <= 1'b1;
		repeat (2) @(posedge clk);
		por_busy <= 1'b0;
		wait_fetch(n0);
		`RXH_CHK(last_fa, `RXH_VEC_HIGH)
		$display("t_hard_abort done");
	endtask : t_hard_abort
	task automatic t_float();
		float_instr_exec <= 1'b1;
		@(posedge clk);
		float_instr_exec <= 1'b0;
		@(posedge clk);
		`RXH_CHK(float_unavail_exc, 1'b1)
		@(posedge clk);
		`RXH_CHK(float_unavail_exc, 1'b0)
		$display("t_float done");
	endtask : t_float
	// Counts, verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst, por_busy, next_done, store_queue_empty, machine_check_take} = 5'b10000;
		{mispredict_next, state_corrupt, float_instr_exec, inv_seen} = 4'h0;
		next_pc = 32'h0000_2468;
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_hard_init();
		t_bus_map();
		t_soft_low();
		t_soft_mc();
		t_soft_corrupt();
		t_soft_short();
		t_hard_abort();
		t_float();
		report_and_stop();
	end
endmodule : rxh_top_tb
